// >>> logic/octc_clock_ctrl.sv
`timescale 1ns/1ps
module octc_clock_ctrl #(
    parameter int FILT_LEN = octc_pkg::FILT_LEN_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fast_osc_tick,
    input wire logic slow_osc_tick,
    input wire logic sleep_active,
    input wire logic clock_input_pin,
    output logic cpu_core_clock_en,
    output logic usb_serial_engine_clock_en,
    output logic interval_timer_clock_en,
    output logic capture_timer_clock_en,
    output logic clock_output_pin,
    output logic slow_wake_tick,
    output logic power_seq_clock_en,
    output logic [2:0] fine_offset,
    output logic [4:0] osc_gain,
    output logic slow_low_power,
    output logic [1:0] slow_bias,
    output logic [3:0] slow_freq_trim,
    output logic osc_lock_enable,
    output logic coarse_tune_enable,
    output logic no_buzz
);
    logic [7:0] main_osc_trim;
    logic [7:0] slow_osc_trim;
    logic [7:0] timer_clock_cfg;
    logic [7:0] osc_lock_cfg;
    logic [7:0] cpu_speed_cfg;
    logic [7:0] clock_route_cfg;
    logic clock_input_pin_s1, clock_input_pin_s2, clock_input_pin_filt, clock_input_pin_prev;
    logic [3:0] filt_cnt;
    logic clock_input_pin_level, clock_input_pin_edge;
    logic slow_ok, slow_tick_ok;
    logic cpu_pulse;
    logic usb_half_act, usb_phase;
    logic [1:0] cap_src_act, it_src_act, out_sel_act;
    logic cap_run, cap_tick, cap_pulse;
    logic it_run, it_tick, it_pulse;
    logic out_tick, out_live;
    logic [15:0] wake_cnt, wake_limit;
    logic [7:0] cpu_div, cap_div, it_div;

    if (FILT_LEN < 1 || FILT_LEN > 15) begin : g_bad_filt
        $error("octc_clock_ctrl: FILT_LEN must be 1 to 15");
    end

    function automatic logic src_tick(input logic [1:0] sel,
            input logic f, input logic s, input logic a);
        unique case (octc_pkg::octc_src_type'(sel))
            octc_pkg::SRC_FAST: src_tick = f;
            octc_pkg::SRC_SLOW: src_tick = s;
            octc_pkg::SRC_ALT: src_tick = a;
            octc_pkg::SRC_RSVD: src_tick = 1'b0;
        endcase
    endfunction

    function automatic logic src_live(input logic [1:0] sel,
            input logic s_ok, input logic a_ok);
        unique case (octc_pkg::octc_src_type'(sel))
            octc_pkg::SRC_FAST: src_live = 1'b1;
            octc_pkg::SRC_SLOW: src_live = s_ok;
            octc_pkg::SRC_ALT: src_live = a_ok;
            octc_pkg::SRC_RSVD: src_live = 1'b0;
        endcase
    endfunction

    // CPU speed code to divisor; reserved code runs as 2^7
    function automatic logic [7:0] speed_div(input logic [2:0] code);
        unique case (code)
            3'h0: speed_div = 8'h08;
            3'h1: speed_div = 8'h04;
            3'h2: speed_div = 8'h02;
            3'h3: speed_div = 8'h01;
            3'h4: speed_div = 8'h10;
            3'h5: speed_div = 8'h20;
            3'h6: speed_div = 8'h80;
            3'h7: speed_div = 8'h80;
        endcase
    endfunction

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_osc_trim <= octc_pkg::RST_MAIN_TRIM;
            slow_osc_trim <= octc_pkg::RST_SLOW_TRIM;
            timer_clock_cfg <= octc_pkg::RST_TMR_CLK;
            osc_lock_cfg <= octc_pkg::RST_OSC_LOCK;
            cpu_speed_cfg <= octc_pkg::RST_SPEED;
            clock_route_cfg <= octc_pkg::RST_CLK_ROUTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                octc_pkg::ADDR_MAIN_TRIM: main_osc_trim <= reg_wdata;
                octc_pkg::ADDR_SLOW_TRIM:
                    slow_osc_trim <= reg_wdata & octc_pkg::MASK_SLOW_TRIM;
                octc_pkg::ADDR_TMR_CLK: timer_clock_cfg <= reg_wdata;
                octc_pkg::ADDR_OSC_LOCK:
                    osc_lock_cfg <= reg_wdata & octc_pkg::MASK_OSC_LOCK;
                octc_pkg::ADDR_SPEED:
                    cpu_speed_cfg <= reg_wdata & octc_pkg::MASK_SPEED;
                octc_pkg::ADDR_CLK_ROUTE:
                    clock_route_cfg <= reg_wdata & octc_pkg::MASK_CLK_ROUTE;
                default: ;
            endcase
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                octc_pkg::ADDR_MAIN_TRIM: reg_rdata <= main_osc_trim;
                octc_pkg::ADDR_SLOW_TRIM: reg_rdata <= slow_osc_trim;
                octc_pkg::ADDR_TMR_CLK: reg_rdata <= timer_clock_cfg;
                octc_pkg::ADDR_OSC_LOCK: reg_rdata <= osc_lock_cfg;
                octc_pkg::ADDR_SPEED: reg_rdata <= cpu_speed_cfg;
                octc_pkg::ADDR_CLK_ROUTE: reg_rdata <= clock_route_cfg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Trim fields straight from the registers
    assign fine_offset = main_osc_trim[7:octc_pkg::FINE_LSB];
    assign osc_gain = main_osc_trim[4:0];
    assign slow_low_power = slow_osc_trim[octc_pkg::SLOW_LP_BIT];
    assign slow_bias = slow_osc_trim[octc_pkg::BIAS_LSB +: 2];
    assign slow_freq_trim = slow_osc_trim[3:0];
    assign osc_lock_enable =
        !osc_lock_cfg[octc_pkg::LOCK_DIS_BIT];
    assign coarse_tune_enable =
        osc_lock_enable && !osc_lock_cfg[octc_pkg::FINE_ONLY_BIT];
    assign no_buzz = cpu_speed_cfg[octc_pkg::NO_BUZZ_BIT];

    // Slow source is not usable while asleep
    assign slow_ok = !sleep_active;
    assign slow_tick_ok = slow_osc_tick && slow_ok;

    // CPU clock
    assign cpu_div = speed_div(cpu_speed_cfg[2:0]);
    octc_pulse_div #(.W(8)) u_cpu_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(fast_osc_tick),
        .run(1'b1),
        .divisor(cpu_div),
        .pulse(cpu_pulse)
    );
    assign cpu_core_clock_en = cpu_pulse;

    // USB clock: halving change adopted only on a whole period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usb_half_act <= 1'b1;
            usb_phase <= 1'b0;
            usb_serial_engine_clock_en <= 1'b0;
        end else if (fast_osc_tick) begin
            usb_serial_engine_clock_en <= !usb_half_act || usb_phase;
            usb_phase <= usb_half_act && !usb_phase;
            if (!usb_half_act || usb_phase) begin
                usb_half_act <= clock_route_cfg[octc_pkg::USB_HALF_BIT];
            end
        end else begin
            usb_serial_engine_clock_en <= 1'b0;
        end
    end

    // Capture clock
    assign cap_run = src_live(cap_src_act, slow_ok, 1'b0);
    assign cap_tick = src_tick(cap_src_act, fast_osc_tick,
        slow_tick_ok, 1'b0);
    assign cap_div = 8'({1'b0, timer_clock_cfg[octc_pkg::CAP_DIV_LSB +: 2]}
        + 3'h1) << 1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_src_act <= octc_pkg::RST_TMR_CLK[octc_pkg::CAP_SEL_LSB +: 2];
        end else if (cap_pulse || !cap_run) begin
            cap_src_act <= timer_clock_cfg[octc_pkg::CAP_SEL_LSB +: 2];
        end
    end
    octc_pulse_div #(.W(8)) u_cap_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(cap_tick),
        .run(cap_run),
        .divisor(cap_div),
        .pulse(cap_pulse)
    );
    assign capture_timer_clock_en = cap_pulse;

    // Interval timer clock
    assign it_run = src_live(it_src_act, slow_ok, cap_run);
    assign it_tick = src_tick(it_src_act, fast_osc_tick,
        slow_tick_ok, cap_pulse);
    assign it_div = 8'({1'b0, timer_clock_cfg[octc_pkg::IT_DIV_LSB +: 2]}
        + 3'h1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            it_src_act <= octc_pkg::RST_TMR_CLK[1:0];
        end else if (it_pulse || !it_run) begin
            it_src_act <= timer_clock_cfg[1:0];
        end
    end
    octc_pulse_div #(.W(8)) u_it_div (
        .clk(clk),
        .rst_n(rst_n),
        .tick(it_tick),
        .run(it_run),
        .divisor(it_div),
        .pulse(it_pulse)
    );
    assign interval_timer_clock_en = it_pulse;

    // Clock input pin: synchroniser and burst filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_input_pin_s1 <= 1'b0;
            clock_input_pin_s2 <= 1'b0;
        end else begin
            clock_input_pin_s1 <= clock_input_pin;
            clock_input_pin_s2 <= clock_input_pin_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_cnt <= 4'h0;
            clock_input_pin_filt <= 1'b0;
        end else if (clock_input_pin_s2 == clock_input_pin_filt) begin
            filt_cnt <= 4'h0;
        end else if (filt_cnt >= 4'(FILT_LEN - 1)) begin
            filt_cnt <= 4'h0;
            clock_input_pin_filt <= clock_input_pin_s2;
        end else begin
            filt_cnt <= filt_cnt + 4'h1;
        end
    end

    assign clock_input_pin_level = clock_route_cfg[octc_pkg::FILT_EN_BIT] ?
        clock_input_pin_filt : clock_input_pin_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_input_pin_prev <= 1'b0;
        end else begin
            clock_input_pin_prev <= clock_input_pin_level;
        end
    end
    assign clock_input_pin_edge = clock_input_pin_level ^ clock_input_pin_prev;

    // Clock output pin toggles on each tick of its source, except a tick on which the source swaps
    always_comb begin
        unique case (octc_pkg::octc_out_type'(out_sel_act))
            octc_pkg::OUT_CLOCK_INPUT_PIN: out_tick = clock_input_pin_edge;
            octc_pkg::OUT_FAST: out_tick = fast_osc_tick;
            octc_pkg::OUT_SLOW: out_tick = slow_tick_ok;
            octc_pkg::OUT_CPU: out_tick = cpu_pulse;
        endcase
    end
    assign out_live = out_sel_act != octc_pkg::OUT_SLOW || slow_ok;

    // Source swap only while low, at a source edge or while the source is not live
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_sel_act <= octc_pkg::RST_CLK_ROUTE[1:0];
            clock_output_pin <= 1'b0;
        end else if (!clock_output_pin && (out_tick || !out_live)
                && out_sel_act != clock_route_cfg[1:0]) begin
            out_sel_act <= clock_route_cfg[1:0];
        end else if (out_tick) begin
            clock_output_pin <= !clock_output_pin;
        end
    end

    // Wakeup period counted on the slow oscillator, even asleep
    always_comb begin
        unique case (cpu_speed_cfg[octc_pkg::SLEEP_LSB +: 2])
            2'h0: wake_limit = octc_pkg::WAKE_DIV_0;
            2'h1: wake_limit = octc_pkg::WAKE_DIV_1;
            2'h2: wake_limit = octc_pkg::WAKE_DIV_2;
            2'h3: wake_limit = octc_pkg::WAKE_DIV_3;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt <= 16'h0000;
            slow_wake_tick <= 1'b0;
        end else if (slow_osc_tick) begin
            if (wake_cnt + 16'h0001 >= wake_limit) begin
                wake_cnt <= 16'h0000;
                slow_wake_tick <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt + 16'h0001;
                slow_wake_tick <= 1'b0;
            end
        end else begin
            slow_wake_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_seq_clock_en <= 1'b0;
        end else begin
            power_seq_clock_en <= slow_osc_tick;
        end
    end

    property p_fine_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == octc_pkg::ADDR_MAIN_TRIM
        |=> fine_offset == $past(reg_wdata[7:5]);
    endproperty
    a_fine_write: assert property (p_fine_write)
        else $error("fine offset did not follow the trim write");

    property p_gain_write;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == octc_pkg::ADDR_MAIN_TRIM
        |=> osc_gain == $past(reg_wdata[4:0]) ##1 $stable(osc_gain)
            || $past(reg_wr);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain did not follow the trim write");

    property p_slow_fields;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == octc_pkg::ADDR_SLOW_TRIM
        |=> slow_bias == $past(reg_wdata[5:4])
            && slow_low_power == $past(reg_wdata[7])
            && slow_freq_trim == $past(reg_wdata[3:0]);
    endproperty
    a_slow_fields: assert property (p_slow_fields)
        else $error("slow trim fields did not follow the write");

    property p_read_slow;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == octc_pkg::ADDR_SLOW_TRIM
        |=> reg_rdata[6] == 1'b0 && reg_rdata[7] == slow_low_power;
    endproperty
    a_read_slow: assert property (p_read_slow)
        else $error("slow trim read back wrong");

    property p_usb_full;
        @(posedge clk) disable iff (!rst_n)
        fast_osc_tick && !usb_half_act |=> usb_serial_engine_clock_en;
    endproperty
    a_usb_full: assert property (p_usb_full)
        else $error("USB clock missed an undivided tick");

    property p_cap_off;
        @(posedge clk) disable iff (!rst_n)
        (cap_src_act == octc_pkg::SRC_ALT)[*2] |-> !capture_timer_clock_en;
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("capture clock ran while disabled");

    property p_cap_sleep;
        @(posedge clk) disable iff (!rst_n)
        (sleep_active && cap_src_act == octc_pkg::SRC_SLOW)[*2]
        |-> !capture_timer_clock_en;
    endproperty
    a_cap_sleep: assert property (p_cap_sleep)
        else $error("capture clock ran from slow source in sleep");

    property p_wake_src;
        @(posedge clk) disable iff (!rst_n)
        slow_wake_tick |-> $past(slow_osc_tick);
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("wakeup tick without a slow oscillator tick");

    property p_lock_off;
        @(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == octc_pkg::ADDR_OSC_LOCK && reg_wdata[0]
        |=> !osc_lock_enable && !coarse_tune_enable;
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("oscillator lock stayed on after disable");
endmodule // octc_clock_ctrl

// >>> logic/octc_pkg.sv
package octc_pkg;
    localparam logic [8:0] ADDR_MAIN_TRIM = 9'h034;
    localparam logic [8:0] ADDR_SLOW_TRIM = 9'h036;
    localparam logic [8:0] ADDR_TMR_CLK = 9'h031;
    localparam logic [8:0] ADDR_OSC_LOCK = 9'h039;
    localparam logic [8:0] ADDR_CLK_ROUTE = 9'h03A;
    localparam logic [8:0] ADDR_SPEED = 9'h1E0;
    localparam logic [7:0] RST_MAIN_TRIM = 8'h00;
    localparam logic [7:0] RST_SLOW_TRIM = 8'h00;
    localparam logic [7:0] RST_TMR_CLK = 8'h0C;
    localparam logic [7:0] RST_OSC_LOCK = 8'h00;
    localparam logic [7:0] RST_SPEED = 8'h00;
    localparam logic [7:0] RST_CLK_ROUTE = 8'h08;
    localparam logic [7:0] MASK_SLOW_TRIM = 8'hBF;
    localparam logic [7:0] MASK_SPEED = 8'h3F;
    localparam logic [7:0] MASK_OSC_LOCK = 8'h03;
    localparam logic [7:0] MASK_CLK_ROUTE = 8'h0F;
    localparam int FINE_LSB = 5;
    localparam int SLOW_LP_BIT = 7;
    localparam int BIAS_LSB = 4;
    localparam int NO_BUZZ_BIT = 5;
    localparam int SLEEP_LSB = 3;
    localparam int CAP_DIV_LSB = 6;
    localparam int CAP_SEL_LSB = 4;
    localparam int IT_DIV_LSB = 2;
    localparam int LOCK_DIS_BIT = 0;
    localparam int FINE_ONLY_BIT = 1;
    localparam int FILT_EN_BIT = 2;
    localparam int USB_HALF_BIT = 3;
    localparam logic [15:0] WAKE_DIV_0 = 16'h0040;
    localparam logic [15:0] WAKE_DIV_1 = 16'h0200;
    localparam logic [15:0] WAKE_DIV_2 = 16'h1000;
    localparam logic [15:0] WAKE_DIV_3 = 16'h8000;
    localparam int FILT_LEN_DEF = 3;
    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_RSVD = 2'b01,
        SRC_SLOW = 2'b10,
        SRC_ALT = 2'b11
    } octc_src_type;
    typedef enum logic [1:0] {
        OUT_CLOCK_INPUT_PIN = 2'b00,
        OUT_FAST = 2'b01,
        OUT_SLOW = 2'b10,
        OUT_CPU = 2'b11
    } octc_out_type;
endpackage

// >>> logic/octc_pulse_div.sv
`timescale 1ns/1ps
module octc_pulse_div #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [W-1:0] divisor,
    output logic pulse
);
    logic [W-1:0] cnt;
    logic [W-1:0] act;

    if (W < 2) begin : g_bad_width
        $error("octc_pulse_div: W must be at least 2");
    end

    // New divisor only adopted at a period boundary or while stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            act <= W'(1);
            pulse <= 1'b0;
        end else if (!run) begin
            cnt <= '0;
            act <= divisor;
            pulse <= 1'b0;
        end else if (tick) begin
            if (cnt + W'(1) >= act) begin
                cnt <= '0;
                act <= divisor;
                pulse <= 1'b1;
            end else begin
                cnt <= cnt + W'(1);
                pulse <= 1'b0;
            end
        end else begin
            pulse <= 1'b0;
        end
    end

    property p_div_gap;
        @(posedge clk) disable iff (!rst_n)
        pulse && act > W'(1) |=> !pulse;
    endproperty
    a_div_gap: assert property (p_div_gap)
        else $error("divider pulse came before its period ended");
endmodule // octc_pulse_div

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        logic [8:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic s;
        int sel;
        int n;
    } octc_row_type;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic fast_osc_tick = 1'h0;
    logic slow_osc_tick = 1'h0;
    logic sleep_active = 1'h0;
    logic clock_input_pin = 1'h0;
    logic cpu_en, usb_en, itmr_en, cap_en, pin, wake, pseq;
    logic slow_lp, lock_en, coarse_en, no_buzz;
    logic [2:0] fine_offset;
    logic [4:0] osc_gain;
    logic [1:0] slow_bias;
    logic [3:0] slow_freq_trim;
    logic [3:0] ph = 4'h0;
    logic counting = 1'h0;
    logic pin_prev = 1'h0;
    int cnt [6];
    int err_total = 0;
    int samples_checked = 0;
    int n;
    // Columns: address, write, readback, sleep, counter, count in 1920
    octc_row_type rows [34] = '{
        '{9'h1E0, 8'h00, 8'h00, 1'h0, 0, 240},
        '{9'h1E0, 8'h01, 8'h01, 1'h0, 0, 480},
        '{9'h1E0, 8'h02, 8'h02, 1'h0, 0, 960},
        '{9'h1E0, 8'h03, 8'h03, 1'h0, 0, 1920},
        '{9'h1E0, 8'h04, 8'h04, 1'h0, 0, 120},
        '{9'h1E0, 8'h05, 8'h05, 1'h0, 0, 60},
        '{9'h1E0, 8'h06, 8'h06, 1'h0, 0, 15},
        '{9'h1E0, 8'hC7, 8'h07, 1'h0, 0, 15},
        '{9'h03A, 8'h08, 8'h08, 1'h0, 1, 960},
        '{9'h03A, 8'h00, 8'h00, 1'h0, 1, 1920},
        '{9'h03A, 8'h00, 8'h00, 1'h0, 4, 240},
        '{9'h03A, 8'h04, 8'h04, 1'h0, 4, 240},
        '{9'h03A, 8'h09, 8'h09, 1'h0, 4, 1920},
        '{9'h03A, 8'h0A, 8'h0A, 1'h0, 4, 480},
        '{9'h03A, 8'h0A, 8'h0A, 1'h1, 4, 0},
        '{9'h03A, 8'hFB, 8'h0B, 1'h0, 4, 15},
        '{9'h031, 8'h00, 8'h00, 1'h0, 2, 1920},
        '{9'h031, 8'h04, 8'h04, 1'h0, 2, 960},
        '{9'h031, 8'h08, 8'h08, 1'h0, 2, 640},
        '{9'h031, 8'h0C, 8'h0C, 1'h0, 2, 480},
        '{9'h031, 8'h00, 8'h00, 1'h0, 3, 960},
        '{9'h031, 8'h40, 8'h40, 1'h0, 3, 480},
        '{9'h031, 8'h80, 8'h80, 1'h0, 3, 320},
        '{9'h031, 8'hC0, 8'hC0, 1'h0, 3, 240},
        '{9'h031, 8'h20, 8'h20, 1'h0, 3, 240},
        '{9'h031, 8'h20, 8'h20, 1'h1, 3, 0},
        '{9'h031, 8'h30, 8'h30, 1'h0, 3, 0},
        '{9'h031, 8'h10, 8'h10, 1'h0, 3, 0},
        '{9'h031, 8'h02, 8'h02, 1'h0, 2, 480},
        '{9'h031, 8'h02, 8'h02, 1'h1, 2, 0},
        '{9'h031, 8'h03, 8'h03, 1'h0, 2, 960},
        '{9'h036, 8'hDF, 8'h9F, 1'h0, 5, 480},
        '{9'h039, 8'hFF, 8'h03, 1'h0, 7, 0},
        '{9'h035, 8'h55, 8'h00, 1'h0, 7, 0}
    };
    logic [8:0] ra [6] = '{octc_pkg::ADDR_MAIN_TRIM, octc_pkg::ADDR_SLOW_TRIM,
        octc_pkg::ADDR_TMR_CLK, octc_pkg::ADDR_OSC_LOCK,
        octc_pkg::ADDR_CLK_ROUTE, octc_pkg::ADDR_SPEED};
    logic [7:0] rv [6] = '{octc_pkg::RST_MAIN_TRIM, octc_pkg::RST_SLOW_TRIM,
        octc_pkg::RST_TMR_CLK, octc_pkg::RST_OSC_LOCK,
        octc_pkg::RST_CLK_ROUTE, octc_pkg::RST_SPEED};

    octc_clock_ctrl i_octc_clock_ctrl (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fast_osc_tick(fast_osc_tick),
        .slow_osc_tick(slow_osc_tick), .sleep_active(sleep_active),
        .clock_input_pin(clock_input_pin), .cpu_core_clock_en(cpu_en),
        .usb_serial_engine_clock_en(usb_en),
        .interval_timer_clock_en(itmr_en), .capture_timer_clock_en(cap_en),
        .clock_output_pin(pin), .slow_wake_tick(wake),
        .power_seq_clock_en(pseq), .fine_offset(fine_offset),
        .osc_gain(osc_gain), .slow_low_power(slow_lp),
        .slow_bias(slow_bias), .slow_freq_trim(slow_freq_trim),
        .osc_lock_enable(lock_en), .coarse_tune_enable(coarse_en),
        .no_buzz(no_buzz)
    );

    always #25 clk = ~clk;

    // Slow ticks every 4 cycles, clock input toggling every 8
    always @(posedge clk) begin
        ph <= ph + 4'h1;
        slow_osc_tick <= (ph[1:0] == 2'h3);
        clock_input_pin <= ph[3];
    end

    always @(posedge clk) begin
        pin_prev <= pin;
        if (counting) begin
            cnt[0] += cpu_en;
            cnt[1] += usb_en;
            cnt[2] += itmr_en;
            cnt[3] += cap_en;
            cnt[4] += (pin != pin_prev);
            cnt[5] += pseq;
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk("read data", 32'(reg_rdata), 32'(e));
        @(posedge clk);
        #1 chk("read idle", 32'(reg_rdata), 32'h0);
    endtask

    // Counts pulses over exactly n edges after settling
    task automatic window(input int n);
        repeat (260) @(posedge clk);
        #1 cnt = '{default: 0};
        counting = 1'h1;
        repeat (n) @(posedge clk);
        #1 counting = 1'h0;
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Tests take about 76,000 cycles; limit at 90,000
    initial begin
        #4500000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        fast_osc_tick <= 1'h1;
        foreach (rows[i]) begin
            @(posedge clk);
            sleep_active <= rows[i].s;
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].r);
            if (rows[i].sel < 6) begin
                window(1920);
                chk("clock count", cnt[rows[i].sel],
                    rows[i].n);
            end
            $display("row %0d done", i);
        end
        // Write then read with no gap, trims follow at once
        @(posedge clk);
        reg_addr <= octc_pkg::ADDR_MAIN_TRIM;
        reg_wdata <= 8'h5A;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        #1 chk("fine offset", 32'(fine_offset), 32'h2);
        chk("gain", 32'(osc_gain), 32'h1A);
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk("back to back read", 32'(reg_rdata), 32'h5A);
        wr(octc_pkg::ADDR_SLOW_TRIM, 8'hDD);
        #1 chk("low power", 32'(slow_lp), 32'h1);
        chk("bias", 32'(slow_bias), 32'h1);
        chk("slow trim", 32'(slow_freq_trim), 32'hD);
        rd(octc_pkg::ADDR_SLOW_TRIM, 8'h9D);
        // Low power cleared by read-modify-write, calibration kept
        rd(octc_pkg::ADDR_SLOW_TRIM, 8'h9D);
        wr(octc_pkg::ADDR_SLOW_TRIM, 8'h9D & 8'h7F);
        #1 chk("calibration kept",
            32'({slow_lp, slow_bias, slow_freq_trim}), 32'h1D);
        wr(octc_pkg::ADDR_OSC_LOCK, 8'h02);
        #1 chk("lock on", 32'({lock_en, coarse_en}), 32'h2);
        wr(octc_pkg::ADDR_OSC_LOCK, 8'h00);
        #1 chk("coarse on", 32'({lock_en, coarse_en}), 32'h3);
        wr(octc_pkg::ADDR_SPEED, 8'h27);
        #1 chk("no buzz", 32'(no_buzz), 32'h1);
        $display("trim test done");
        // Wake period: 64, then 512 slow ticks of 4 cycles
        for (int w = 0; w < 2; w++) begin
            if (w == 1)
                wr(octc_pkg::ADDR_SPEED, 8'h08);
            n = 0;
            while (!wake && n < 2200) begin
                @(posedge clk);
                #1 n++;
            end
            n = 0;
            do begin
                @(posedge clk);
                #1 n++;
            end while (!wake && n < 2200);
            chk("wake period", n, w == 0 ? 256 : 2048);
        end
        $display("wake test done");
        // Reset in mid-run
        @(posedge clk);
        rst_n <= 1'h0;
        #1 chk("fine offset reset", 32'(fine_offset), 32'h0);
        chk("gain reset", 32'(osc_gain), 32'h0);
        chk("slow trim reset", 32'(slow_freq_trim), 32'h0);
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        foreach (ra[k])
            rd(ra[k], rv[k]);
        window(1920);
        chk("cpu after reset", cnt[0], 240);
        $display("reset test done");
        close_out();
    end
endmodule // tb_top
